// file: src/motor_fault_protection.sv
// fault protection monitor for a permanent magnet motor drive
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/100ps
module motor_fault_protection #(
	parameter int TICK_CYCLES = mfp_pkg::TICK_CYCLES,
	parameter int DW = mfp_pkg::DW
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire mfp_pkg::bus_req_type bus_req_i,
	output logic [DW-1:0] rd_data_o,
	input wire mfp_pkg::sense_type sense_i,
	output logic pwm_trap_o,
	output logic speed_loop_reset_o,
	output logic motor_fault_o,
	output logic [DW-1:0] comp_trip_level_o
);

	logic [2:0] ctrl_ff;
	logic [DW-1:0] fault_enable_mask_ff;
	logic [DW-1:0] flux_fault_response_time_ff;
	logic [DW-1:0] lock_detect_time_ff;
	logic [DW-1:0] overcurrent_debounce_time_ff;
	logic [DW-1:0] comparator_trip_level_ff;
	logic [DW-1:0] temp_threshold_ff;
	logic [DW-1:0] speed_min_ff;
	logic [DW-1:0] speed_max_ff;
	logic [DW-1:0] fault_flag_word_ff;
	logic [DW-1:0] nxt_fault_flag_word;
	logic [DW-1:0] reported_fault_word;
	logic [DW-1:0] rep_mask;
	logic [DW-1:0] fault_set;
	logic [DW-1:0] rd_data_ff;
	logic [DW-1:0] slot_len;
	logic [DW-1:0] slot_cnt_ff;
	logic [3:0] bad_slots_ff;
	logic slot_bad_ff;
	logic flux_out;
	logic slot_end;
	logic flux_hit;
	logic trap_ff;
	logic speed_reset_ff;
	logic tick;
	logic fault_clear_cmd;
	logic lock_active;
	logic lock_cond;
	logic lock_hit;
	logic comp_any;
	logic filter_in;
	logic oc_hit;
	logic otemp_cond;
	logic [DW-1:0] wr_clamped;
	mfp_pkg::motor_state_type state_ff;

	// ======================================================
	// register writes
	// clear by writing one
	assign fault_clear_cmd = bus_req_i.wr && bus_req_i.addr == mfp_pkg::OFS_FAULT_CLEAR && bus_req_i.wdata[0];

	always_comb
	begin
		wr_clamped = bus_req_i.wdata;
		if (bus_req_i.wdata < mfp_pkg::DEBOUNCE_MIN)
			wr_clamped = mfp_pkg::DEBOUNCE_MIN;
		else if (bus_req_i.wdata > mfp_pkg::DEBOUNCE_MAX)
			wr_clamped = mfp_pkg::DEBOUNCE_MAX;
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ctrl_ff <= mfp_pkg::CTRL_RST;
			fault_enable_mask_ff <= mfp_pkg::ENABLE_RST;
			flux_fault_response_time_ff <= mfp_pkg::FLUX_TIME_RST;
			lock_detect_time_ff <= mfp_pkg::LOCK_TIME_RST;
			overcurrent_debounce_time_ff <= mfp_pkg::DEBOUNCE_RST;
			comparator_trip_level_ff <= mfp_pkg::COMP_LEVEL_RST;
			temp_threshold_ff <= mfp_pkg::TEMP_THRESHOLD_RST;
			speed_min_ff <= mfp_pkg::SPEED_MIN_RST;
			speed_max_ff <= mfp_pkg::SPEED_MAX_RST;
		end
		else if (bus_req_i.wr)
		begin
			case (bus_req_i.addr)
				mfp_pkg::OFS_CTRL: ctrl_ff <= bus_req_i.wdata[2:0];
				mfp_pkg::OFS_FAULT_ENABLE: fault_enable_mask_ff <= bus_req_i.wdata;
				mfp_pkg::OFS_FLUX_TIME: flux_fault_response_time_ff <= bus_req_i.wdata;
				mfp_pkg::OFS_LOCK_TIME: lock_detect_time_ff <= bus_req_i.wdata;
				mfp_pkg::OFS_DEBOUNCE_TIME: overcurrent_debounce_time_ff <= wr_clamped;
				mfp_pkg::OFS_COMP_LEVEL: comparator_trip_level_ff <= bus_req_i.wdata;
				mfp_pkg::OFS_TEMP_THRESHOLD: temp_threshold_ff <= bus_req_i.wdata;
				mfp_pkg::OFS_SPEED_MIN: speed_min_ff <= bus_req_i.wdata;
				mfp_pkg::OFS_SPEED_MAX: speed_max_ff <= bus_req_i.wdata;
				default: ;
			endcase
		end
	end

	assign comp_trip_level_o = comparator_trip_level_ff;

	// ======================================================
	// register reads
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rd_data_ff <= '0;
		else if (bus_req_i.rd)
		begin
			case (bus_req_i.addr)
				mfp_pkg::OFS_CTRL: rd_data_ff <= {13'h0000, ctrl_ff};
				mfp_pkg::OFS_FAULT_ENABLE: rd_data_ff <= fault_enable_mask_ff;
				mfp_pkg::OFS_FLUX_TIME: rd_data_ff <= flux_fault_response_time_ff;
				mfp_pkg::OFS_LOCK_TIME: rd_data_ff <= lock_detect_time_ff;
				mfp_pkg::OFS_DEBOUNCE_TIME: rd_data_ff <= overcurrent_debounce_time_ff;
				mfp_pkg::OFS_COMP_LEVEL: rd_data_ff <= comparator_trip_level_ff;
				mfp_pkg::OFS_TEMP_THRESHOLD: rd_data_ff <= temp_threshold_ff;
				mfp_pkg::OFS_SPEED_MIN: rd_data_ff <= speed_min_ff;
				mfp_pkg::OFS_SPEED_MAX: rd_data_ff <= speed_max_ff;
				mfp_pkg::OFS_FLAG_WORD: rd_data_ff <= fault_flag_word_ff;
				mfp_pkg::OFS_REPORTED_WORD: rd_data_ff <= reported_fault_word;
				mfp_pkg::OFS_STATUS: rd_data_ff <= {14'h0000, trap_ff, state_ff == mfp_pkg::ST_FAULT};
				default: rd_data_ff <= '0;
			endcase
		end
		else
			rd_data_ff <= '0;
	end

	assign rd_data_o = rd_data_ff;

	// ======================================================
	// timebase
	// 10 ms tick
	mfp_tick_gen #(
		.PERIOD(TICK_CYCLES)
	) u_tick (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.tick_o(tick)
	);

	// ======================================================
	// flux supervision
	// window around nominal
	assign flux_out = sense_i.flux_mag < mfp_pkg::FLUX_LOW || sense_i.flux_mag > mfp_pkg::FLUX_HIGH;

	always_comb
	begin
		slot_len = flux_fault_response_time_ff >> mfp_pkg::FLUX_SLOT_SHIFT;
		if (slot_len == '0)
			slot_len = 16'h0001;
	end

	assign slot_end = tick && (slot_cnt_ff + 16'h0001 >= slot_len);

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			slot_cnt_ff <= '0;
		else if (slot_end)
			slot_cnt_ff <= '0;
		else if (tick)
			slot_cnt_ff <= slot_cnt_ff + 16'h0001;
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			slot_bad_ff <= 1'h0;
		else if (slot_end)
			slot_bad_ff <= 1'h0;
		else if (flux_out)
			slot_bad_ff <= 1'h1;
	end

	// eight bad slots in a row
	assign flux_hit = slot_end && (slot_bad_ff || flux_out) && (bad_slots_ff == mfp_pkg::FLUX_SLOTS - 4'h1);

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			bad_slots_ff <= 4'h0;
		else if (slot_end)
		begin
			if (!(slot_bad_ff || flux_out) || flux_hit)
				bad_slots_ff <= 4'h0;
			else
				bad_slots_ff <= bad_slots_ff + 4'h1;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			speed_reset_ff <= 1'h0;
		else
			speed_reset_ff <= flux_hit;
	end

	assign speed_loop_reset_o = speed_reset_ff;

	// ======================================================
	// locked rotor
	// active up to a quarter of max speed
	assign lock_active = sense_i.speed >= speed_min_ff && sense_i.speed <= (speed_max_ff >> 2);
	assign lock_cond = lock_active && sense_i.torque_sat;

	mfp_persist #(
		.W(DW)
	) u_lock (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.cond_i(lock_cond),
		.step_i(tick),
		.limit_i(lock_detect_time_ff),
		.hit_o(lock_hit),
		.count_o()
	);

	// ======================================================
	// overcurrent
	// single shunt one comparator, leg one
	assign comp_any = ctrl_ff[mfp_pkg::CTRL_LEG_SHUNT] ? (|sense_i.comp_trip) : sense_i.comp_trip[0];

	assign filter_in = (ctrl_ff[mfp_pkg::CTRL_SRC_PIN] && !sense_i.kill_input_pin_n)
		|| (ctrl_ff[mfp_pkg::CTRL_SRC_COMP] && comp_any);

	mfp_persist #(
		.W(DW)
	) u_debounce (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.cond_i(filter_in),
		.step_i(1'b1),
		.limit_i(overcurrent_debounce_time_ff),
		.hit_o(oc_hit),
		.count_o()
	);

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			trap_ff <= 1'h0;
		else if (oc_hit)
			trap_ff <= 1'h1;
		else if (fault_clear_cmd)
			trap_ff <= 1'h0;
	end

	assign pwm_trap_o = trap_ff || oc_hit;

	// ======================================================
	// over-temperature
	// below shutdown threshold
	assign otemp_cond = sense_i.temp_sense < temp_threshold_ff;

	// ======================================================
	// flags and state
	// bits 0, 4, 6 and 7
	always_comb
	begin
		fault_set = '0;
		fault_set[mfp_pkg::BIT_OVERCURRENT] = oc_hit;
		fault_set[mfp_pkg::BIT_FLUX] = flux_hit;
		fault_set[mfp_pkg::BIT_OTEMP] = otemp_cond;
		fault_set[mfp_pkg::BIT_LOCK] = lock_hit;
	end

	// set wins over clear
	assign nxt_fault_flag_word = (fault_clear_cmd ? '0 : fault_flag_word_ff) | fault_set;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			fault_flag_word_ff <= '0;
		else
			fault_flag_word_ff <= nxt_fault_flag_word;
	end

	assign rep_mask = fault_enable_mask_ff | mfp_pkg::UNMASKABLE;
	assign reported_fault_word = fault_flag_word_ff & rep_mask;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			state_ff <= mfp_pkg::ST_RUN;
		else
		begin
			case (state_ff)
				mfp_pkg::ST_RUN:
					if (|(nxt_fault_flag_word & rep_mask))
						state_ff <= mfp_pkg::ST_FAULT;
				mfp_pkg::ST_FAULT:
					if (!(|(nxt_fault_flag_word & rep_mask)))
						state_ff <= mfp_pkg::ST_RUN;
				default: state_ff <= mfp_pkg::ST_RUN;
			endcase
		end
	end

	assign motor_fault_o = state_ff == mfp_pkg::ST_FAULT;

	// ======================================================
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_oc_trip;
		oc_hit ##1 (trap_ff && motor_fault_o && fault_flag_word_ff[mfp_pkg::BIT_OVERCURRENT]);
	endsequence

	chk_oc_trap_now: assert property (oc_hit |-> pwm_trap_o)
		else $error("trap not immediate");
	chk_oc_unmasked: assert property (oc_hit |-> s_oc_trip)
		else $error("overcurrent did not force fault");
	chk_trap_held: assert property (trap_ff && !fault_clear_cmd |=> trap_ff)
		else $error("trap dropped without clear");
	chk_flux_flag: assert property (flux_hit |=> fault_flag_word_ff[mfp_pkg::BIT_FLUX] && speed_loop_reset_o)
		else $error("flux fault not flagged");
	chk_flux_slots: assert property (slot_end && !(slot_bad_ff || flux_out) |=> bad_slots_ff == 4'h0)
		else $error("good flux slot did not restart the run");
	chk_mask_run: assert property (!motor_fault_o && !(|(nxt_fault_flag_word & rep_mask)) |=> !motor_fault_o)
		else $error("masked fault entered fault state");
	chk_otemp_flag: assert property (otemp_cond |=> fault_flag_word_ff[mfp_pkg::BIT_OTEMP])
		else $error("over-temperature not flagged");
	chk_lock_range: assert property (lock_hit |-> sense_i.speed <= (speed_max_ff >> 2) && sense_i.torque_sat)
		else $error("lock detected out of range");
	chk_debounce_range: assert property (overcurrent_debounce_time_ff >= mfp_pkg::DEBOUNCE_MIN
		&& overcurrent_debounce_time_ff <= mfp_pkg::DEBOUNCE_MAX)
		else $error("debounce time out of range");

endmodule

// file: src/mfp_pkg.sv
// shared constants and types of the motor fault protection block
package mfp_pkg;

	// ======================================================
	// register bus
	localparam int DW = 16;
	localparam int AW = 4;
	localparam logic [AW-1:0] OFS_CTRL = 4'h0;
	localparam logic [AW-1:0] OFS_FAULT_ENABLE = 4'h1;
	localparam logic [AW-1:0] OFS_FLUX_TIME = 4'h2;
	localparam logic [AW-1:0] OFS_LOCK_TIME = 4'h3;
	localparam logic [AW-1:0] OFS_DEBOUNCE_TIME = 4'h4;
	localparam logic [AW-1:0] OFS_COMP_LEVEL = 4'h5;
	localparam logic [AW-1:0] OFS_TEMP_THRESHOLD = 4'h6;
	localparam logic [AW-1:0] OFS_SPEED_MIN = 4'h7;
	localparam logic [AW-1:0] OFS_SPEED_MAX = 4'h8;
	localparam logic [AW-1:0] OFS_FAULT_CLEAR = 4'h9;
	localparam logic [AW-1:0] OFS_FLAG_WORD = 4'hA;
	localparam logic [AW-1:0] OFS_REPORTED_WORD = 4'hB;
	localparam logic [AW-1:0] OFS_STATUS = 4'hC;

	// ======================================================
	// field positions
	localparam int CTRL_SRC_PIN = 0;
	localparam int CTRL_SRC_COMP = 1;
	localparam int CTRL_LEG_SHUNT = 2;
	localparam int BIT_OVERCURRENT = 0;
	localparam int BIT_FLUX = 4;
	localparam int BIT_OTEMP = 6;
	localparam int BIT_LOCK = 7;
	localparam logic [DW-1:0] UNMASKABLE = 16'h0001;

	// ======================================================
	// reset values and limits
	localparam logic [2:0] CTRL_RST = 3'h3;
	localparam logic [DW-1:0] ENABLE_RST = 16'h00D1;
	localparam logic [DW-1:0] FLUX_TIME_RST = 16'h0320;
	localparam logic [DW-1:0] LOCK_TIME_RST = 16'h0064;
	localparam logic [DW-1:0] DEBOUNCE_RST = 16'h0060;
	localparam logic [DW-1:0] DEBOUNCE_MIN = 16'h0004;
	localparam logic [DW-1:0] DEBOUNCE_MAX = 16'h03C0;
	localparam logic [DW-1:0] COMP_LEVEL_RST = 16'h0000;
	localparam logic [DW-1:0] TEMP_THRESHOLD_RST = 16'h0000;
	localparam logic [DW-1:0] SPEED_MIN_RST = 16'h0000;
	localparam logic [DW-1:0] SPEED_MAX_RST = 16'hFFFF;

	// ======================================================
	// flux supervision
	localparam logic [DW-1:0] FLUX_NOMINAL = 16'h0800;
	localparam logic [DW-1:0] FLUX_LOW = 16'h0200;
	localparam logic [DW-1:0] FLUX_HIGH = 16'h2000;
	localparam logic [3:0] FLUX_SLOTS = 4'h8;
	localparam int FLUX_SLOT_SHIFT = 3;

	// ======================================================
	// timebase
	localparam int TICK_MS = 10;
	localparam int CLK_KHZ = 50000;
	localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;

	typedef enum logic [0:0] {
		ST_RUN = 1'h0,
		ST_FAULT = 1'h1
	} motor_state_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
	} bus_req_type;

	typedef struct packed {
		logic [DW-1:0] flux_mag;
		logic [DW-1:0] speed;
		logic torque_sat;
		logic [DW-1:0] temp_sense;
		logic kill_input_pin_n;
		logic [2:0] comp_trip;
	} sense_type;

endpackage

// file: src/mfp_tick_gen.sv
// one-cycle enable pulse every PERIOD clock cycles
`timescale 1ns/100ps
module mfp_tick_gen #(
	parameter int PERIOD = mfp_pkg::TICK_CYCLES
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	output logic tick_o
);

	logic [31:0] cnt_ff;

	// ======================================================
	// divider
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cnt_ff <= 32'h00000000;
			tick_o <= 1'h0;
		end
		else if (cnt_ff >= 32'(PERIOD - 1))
		begin
			cnt_ff <= 32'h00000000;
			tick_o <= 1'h1;
		end
		else
		begin
			cnt_ff <= cnt_ff + 32'h00000001;
			tick_o <= 1'h0;
		end
	end

endmodule

// file: src/mfp_persist.sv
// counts while a condition persists, clears at once when it drops
`timescale 1ns/100ps
module mfp_persist #(
	parameter int W = 16
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic cond_i,
	input wire logic step_i,
	input wire logic [W-1:0] limit_i,
	output logic hit_o,
	output logic [W-1:0] count_o
);

	logic [W-1:0] cnt_ff;

	// ======================================================
	// counter
	// count up, clear
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cnt_ff <= '0;
		else if (!cond_i)
			cnt_ff <= '0;
		else if (step_i && cnt_ff != {W{1'h1}})
			cnt_ff <= cnt_ff + 1'h1;
	end

	assign hit_o = cond_i && (cnt_ff >= limit_i);
	assign count_o = cnt_ff;

	// ======================================================
	// checks
	chk_count_clears: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		!cond_i |=> cnt_ff == '0)
		else $error("persist counter not cleared");

endmodule

// file: verif/inverter_stage_model.sv
// sensing side of the inverter power stage seen by the fault monitor
`timescale 1ns/100ps
module inverter_stage_model (
	input wire logic oc_pin_i,
	input wire logic [2:0] oc_comp_i,
	input wire logic [15:0] flux_i,
	input wire logic [15:0] speed_i,
	input wire logic sat_i,
	input wire logic [15:0] temp_i,
	output mfp_pkg::sense_type sense_o
);
	// ======================================================
	// sensed values
	always_comb
	begin
		sense_o.flux_mag = flux_i;
		sense_o.speed = speed_i;
		sense_o.torque_sat = sat_i;
		sense_o.temp_sense = temp_i;
		sense_o.kill_input_pin_n = ~oc_pin_i;
		sense_o.comp_trip = oc_comp_i;
	end
endmodule

// file: verif/testbench.sv
// self-checking testbench of the motor fault protection block
`timescale 1ns/100ps
module testbench;
	localparam int TICKS = 10;
	logic mclk_i = 1'h0;
	logic resetn_i = 1'h0;
	mfp_pkg::bus_req_type req = '0;
	mfp_pkg::sense_type sense;
	logic [15:0] rd_data;
	logic [15:0] comp_level;
	logic trap;
	logic loop_rst;
	logic fault;
	logic oc_pin = 1'h0;
	logic [2:0] oc_comp = 3'h0;
	logic [15:0] flux = 16'h0800;
	logic [15:0] speed = 16'h0000;
	logic [15:0] temp = 16'hFFFF;
	logic sat = 1'h0;
	logic [15:0] rst_val [0:13] = '{16'h0003, 16'h00D1, 16'h0320, 16'h0064, 16'h0060, 16'h0000, 16'h0000,
		16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	logic [2:0] c_ctrl [0:5] = '{3'h2, 3'h1, 3'h2, 3'h6, 3'h2, 3'h3};
	logic [2:0] c_comp [0:5] = '{3'h0, 3'h7, 3'h6, 3'h4, 3'h1, 3'h0};
	logic c_pin [0:5] = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
	logic c_trap [0:5] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
	int fails = 0;
	int checked = 0;

	always #10 mclk_i = ~mclk_i;

	motor_fault_protection #(.TICK_CYCLES(TICKS)) dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .bus_req_i(req),
		.rd_data_o(rd_data), .sense_i(sense), .pwm_trap_o(trap), .speed_loop_reset_o(loop_rst),
		.motor_fault_o(fault), .comp_trip_level_o(comp_level));
	inverter_stage_model model (.oc_pin_i(oc_pin), .oc_comp_i(oc_comp), .flux_i(flux), .speed_i(speed),
		.sat_i(sat), .temp_i(temp), .sense_o(sense));

	// ======================================================
	// shared tasks
	task automatic wrap_up;
	begin
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask

	task automatic check(input logic ok, input string msg);
	begin
		checked++;
		if (ok !== 1'h1)
		begin
			fails++;
			$display("[ERR] %0t %s", $time, msg);
		end
	end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
	begin
		@(posedge mclk_i);
		req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
		@(posedge mclk_i);
		req <= '0;
		#1;
	end
	endtask

	task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
	begin
		@(posedge mclk_i);
		req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 16'h0000};
		@(posedge mclk_i);
		req <= '0;
		#1;
		check(rd_data === exp, "read data mismatch");
	end
	endtask

	task automatic settle(input int n);
	begin
		repeat (n) @(posedge mclk_i);
		#1;
	end
	endtask

	task automatic clear_all;
	begin
		@(posedge mclk_i);
		oc_pin <= 1'h0;
		oc_comp <= 3'h0;
		flux <= 16'h0800;
		sat <= 1'h0;
		temp <= 16'hFFFF;
		reg_wr(mfp_pkg::OFS_FAULT_CLEAR, 16'h0001);
		check(fault === 1'h0 && trap === 1'h0, "fault not cleared");
	end
	endtask

	task automatic wait_fault(input int lo, input int hi, output int pulses);
		int n;
	begin
		n = 0;
		pulses = 0;
		while (fault !== 1'h1 && n < hi + 10)
		begin
			settle(1);
			n++;
			if (loop_rst === 1'h1)
				pulses++;
		end
		if (fault !== 1'h1)
		begin
			fails++;
			$display("[ERR] %0t wait for fault ran out", $time);
			wrap_up();
		end
		check(n >= lo && n <= hi, "fault outside time window");
		repeat (3)
		begin
			settle(1);
			if (loop_rst === 1'h1)
				pulses++;
		end
	end
	endtask

	// ======================================================
	// scenarios
	task automatic t_reset;
	begin
		check(fault === 1'h0 && trap === 1'h0 && comp_level === 16'h0000, "outputs after reset");
		for (int i = 0; i < 14; i++)
			reg_rd(4'(i), rst_val[i]);
		reg_wr(mfp_pkg::OFS_COMP_LEVEL, 16'h0ABC);
		check(comp_level === 16'h0ABC, "comparator level not applied");
		reg_wr(mfp_pkg::OFS_DEBOUNCE_TIME, 16'h0001);
		reg_rd(mfp_pkg::OFS_DEBOUNCE_TIME, 16'h0004);
		reg_wr(mfp_pkg::OFS_DEBOUNCE_TIME, 16'h03E8);
		reg_rd(mfp_pkg::OFS_DEBOUNCE_TIME, 16'h03C0);
		reg_wr(mfp_pkg::OFS_DEBOUNCE_TIME, 16'h0004);
		reg_wr(mfp_pkg::OFS_FLUX_TIME, 16'hFFFF);
		reg_rd(mfp_pkg::OFS_FLUX_TIME, 16'hFFFF);
	end
	endtask

	task automatic t_overcurrent;
	begin
		reg_wr(mfp_pkg::OFS_CTRL, 16'h0001);
		@(posedge mclk_i);
		oc_pin <= 1'h1;
		repeat (3) @(posedge mclk_i);
		oc_pin <= 1'h0;
		@(posedge mclk_i);
		oc_pin <= 1'h1;
		settle(3);
		check(trap === 1'h0, "debounce not restarted");
		settle(1);
		check(trap === 1'h1, "trap not at filter time");
		settle(1);
		check(fault === 1'h1, "no fault state on overcurrent");
		reg_wr(mfp_pkg::OFS_FAULT_ENABLE, 16'h0000);
		reg_rd(mfp_pkg::OFS_REPORTED_WORD, 16'h0001);
		reg_wr(mfp_pkg::OFS_FAULT_CLEAR, 16'h0001);
		check(trap === 1'h1 && fault === 1'h1, "overcurrent cleared while present");
		clear_all();
		reg_wr(mfp_pkg::OFS_FAULT_ENABLE, 16'h00D1);
	end
	endtask

	task automatic t_sources;
	begin
		for (int i = 0; i < 6; i++)
		begin
			reg_wr(mfp_pkg::OFS_CTRL, {13'h0000, c_ctrl[i]});
			@(posedge mclk_i);
			oc_pin <= c_pin[i];
			oc_comp <= c_comp[i];
			settle(8);
			check(trap === c_trap[i], "overcurrent source selection");
			clear_all();
		end
	end
	endtask

	task automatic t_otemp;
	begin
		reg_wr(mfp_pkg::OFS_TEMP_THRESHOLD, 16'h0100);
		reg_wr(mfp_pkg::OFS_FAULT_ENABLE, 16'h0091);
		@(posedge mclk_i);
		temp <= 16'h0100;
		reg_rd(mfp_pkg::OFS_FLAG_WORD, 16'h0000);
		@(posedge mclk_i);
		temp <= 16'h00FF;
		reg_rd(mfp_pkg::OFS_FLAG_WORD, 16'h0040);
		reg_rd(mfp_pkg::OFS_REPORTED_WORD, 16'h0000);
		check(fault === 1'h0, "masked over-temperature stopped motor");
		reg_wr(mfp_pkg::OFS_FAULT_ENABLE, 16'h00D1);
		settle(2);
		check(fault === 1'h1, "enabled over-temperature ignored");
		reg_rd(mfp_pkg::OFS_REPORTED_WORD, 16'h0040);
		clear_all();
	end
	endtask

	task automatic t_lock;
		int p;
	begin
		reg_wr(mfp_pkg::OFS_LOCK_TIME, 16'h0003);
		reg_wr(mfp_pkg::OFS_SPEED_MAX, 16'h0190);
		@(posedge mclk_i);
		speed <= 16'h0064;
		sat <= 1'h1;
		wait_fault(2 * TICKS, 4 * TICKS + 5, p);
		reg_rd(mfp_pkg::OFS_FLAG_WORD, 16'h0080);
		clear_all();
		@(posedge mclk_i);
		speed <= 16'h0065;
		sat <= 1'h1;
		settle(10 * TICKS);
		check(fault === 1'h0, "lock detected above quarter speed");
		reg_wr(mfp_pkg::OFS_SPEED_MIN, 16'h0020);
		@(posedge mclk_i);
		speed <= 16'h0010;
		settle(10 * TICKS);
		check(fault === 1'h0, "lock detected below minimum speed");
		clear_all();
		reg_wr(mfp_pkg::OFS_SPEED_MIN, 16'h0000);
	end
	endtask

	task automatic t_flux;
		int p;
	begin
		reg_wr(mfp_pkg::OFS_FLUX_TIME, 16'h0008);
		settle(15 * TICKS);
		check(fault === 1'h0, "fault on nominal flux");
		@(posedge mclk_i);
		flux <= 16'h01FF;
		wait_fault(6 * TICKS, 9 * TICKS + 5, p);
		check(p == 1, "speed loop reset not one pulse");
		reg_rd(mfp_pkg::OFS_FLAG_WORD, 16'h0010);
		clear_all();
		reg_wr(mfp_pkg::OFS_FLUX_TIME, 16'h0010);
		@(posedge mclk_i);
		flux <= 16'h2001;
		wait_fault(13 * TICKS, 18 * TICKS + 5, p);
		clear_all();
		reg_wr(mfp_pkg::OFS_FAULT_ENABLE, 16'h00C1);
		@(posedge mclk_i);
		flux <= 16'h0000;
		settle(25 * TICKS);
		check(fault === 1'h0, "masked flux fault stopped motor");
		reg_rd(mfp_pkg::OFS_FLAG_WORD, 16'h0010);
		reg_rd(mfp_pkg::OFS_REPORTED_WORD, 16'h0000);
		clear_all();
		reg_wr(mfp_pkg::OFS_FAULT_ENABLE, 16'h00D1);
	end
	endtask

	// ======================================================
	// main sequence
	initial
	begin
		repeat (8) @(posedge mclk_i);
		resetn_i <= 1'h1;
		t_reset();
		t_overcurrent();
		t_sources();
		t_otemp();
		t_lock();
		t_flux();
		wrap_up();
	end
endmodule
